// ### rtl/bdt_defs.vh
// Purpose : Shared offsets, field positions and reset values for the
//           backup domain tamper unit.
// Assumes : Byte addressing on a 32-bit APB, one aligned word per register.
// Notes   : Definitions only.
`ifndef BDT_DEFS_VH
`define BDT_DEFS_VH

// ============================================================
// Register byte offsets
`define BDT_OFS_DATA_FIRST 8'h04
`define BDT_OFS_DATA_LAST  8'h28
`define BDT_OFS_CAL        8'h2C
`define BDT_OFS_TCTL       8'h30
`define BDT_OFS_TCSR       8'h34
`define BDT_OFS_DCTL       8'h3C

// ============================================================
// Geometry of the retained store
`define BDT_NUM_WORDS      10
`define BDT_WORD_W         16
`define BDT_IDX_W          4

// ============================================================
// Calibration register fields
`define BDT_CAL_LSB        0
`define BDT_CAL_W          7
`define BDT_CCO_BIT        7
`define BDT_POE_BIT        8
`define BDT_POS_BIT        9

// ============================================================
// Tamper control and status fields
`define BDT_TPE_BIT        0
`define BDT_TAMPER_ACTIVE_LEVEL_BIT       1
`define BDT_CTE_BIT        0
`define BDT_CTI_BIT        1
`define BDT_TPIE_BIT       2
`define BDT_TEF_BIT        8
`define BDT_TIF_BIT        9

// ============================================================
// Domain control fields
`define BDT_POWER_IF_CLOCK_ENABLE_BIT      0
`define BDT_BIFEN_BIT      1
`define BDT_UNLOCK_BIT     2
`define BDT_BIFRST_BIT     3
`define BDT_BACKUP_DOMAIN_SOFT_RESET_BIT      16

// ============================================================
// Timing and reset values
`define BDT_DIV_HALF       5'h1F
`define BDT_WIN_W          20
`define BDT_RST_WORD       16'h0000

`endif

// ### rtl/bdt_sync.v
// Purpose : Three-stage synchroniser with agreement filter for a pin.
// Assumes : din is asynchronous to clk.
// Notes   : The output moves only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module bdt_sync (
  input  wire clk,
  input  wire rst_n,
  input  wire din,
  output wire dout
);

  reg s1_r;
  reg s2_r;
  reg s3_r;
  reg out_r;

  // ============================================================
  // Stage one feeds stage two only, so metastability stays contained.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r  <= 1'b0;
      s2_r  <= 1'b0;
      s3_r  <= 1'b0;
      out_r <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        out_r <= s3_r;  // Agreement filters single-cycle glitches.
      end
    end
  end

  assign dout = out_r;

endmodule // bdt_sync

`default_nettype wire

// ### rtl/bdt_mem.v
// Purpose : Ten retained 16-bit words with a one-cycle clear-all.
// Assumes : rst_n is the battery domain power-on reset.
// Notes   : Read data come out of a register one cycle after raddr.
`timescale 1ns/1ps
`default_nettype none
`include "bdt_defs.vh"

module bdt_mem #(
  parameter DEPTH = `BDT_NUM_WORDS,
  parameter WIDTH = `BDT_WORD_W,
  parameter AW    = `BDT_IDX_W
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             clr,
  input  wire             we,
  input  wire [AW-1:0]    waddr,
  input  wire [WIDTH-1:0] wdata,
  input  wire [AW-1:0]    raddr,
  output wire [WIDTH-1:0] rdata
);

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [WIDTH-1:0] rdata_r;
  integer         i;

  // ============================================================
  // Clear wins over a write in the same cycle, so no word survives.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_r[i] <= `BDT_RST_WORD;
      end
    end else if (clr) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_r[i] <= `BDT_RST_WORD;
      end
    end else if (we) begin
      mem_r[waddr] <= wdata;
    end
  end

  // ============================================================
  // Registered read port.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= `BDT_RST_WORD;
    end else begin
      rdata_r <= mem_r[raddr];
    end
  end

  assign rdata = rdata_r;

endmodule // bdt_mem

`default_nettype wire

// ### rtl/bdt_top.v
// Purpose : Backup domain unit: retained words, tamper detection,
//           calibration clock and pulse output on the tamper pin.
// Assumes : pclk keeps running from the battery supply; rtc_tick is a
//           one-cycle pulse per RTC clock on pclk.
// Notes   : Every transfer takes one wait state before pready.
`timescale 1ns/1ps
`default_nettype none
`include "bdt_defs.vh"

// Behaviour
// R1: Ten 16-bit words kept on battery.
// R2: Access needs clocks enabled, writes need unlock.
// R3: Active-direction pin edge makes tamper event.
// R4: Tamper event clears every data word.
// R5: Enabled interrupt raised with the event.
// R6: Edges latched while disabled, delivered on enable.
// R7: Pin already active: enabling gives extra event.
// R8: Software clears event memory before starting.
// R9: Tamper logic runs on battery domain.
// R10: Software disables tamper before pin outputs.
// R11: Pulse enable drives second or alarm pulse.
// R12: Calibration bit drives RTC clock over 64.
// R13: Software tunes RTC with 7-bit field.
// R14: Domain reset clears words, pulse bits only; the code also clears cal, cco and all tamper enables, flags and pending state.
// R15: Level bit zero rising, one falling.
// R16: Pulse select one second, zero alarm.
// R17: Drop field count ticks per 2^20.
// R18: Clearing level and enable together falsely fires.
// R19: Pin synchronised; interrupt flag sticky until cleared.
module bdt_top #(
  parameter WIN_W = `BDT_WIN_W
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        bat_rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        tamper_in,
  output wire        tamper_out,
  output wire        tamper_oe_n,
  input  wire        rtc_tick,
  input  wire        rtc_alarm_pulse,
  input  wire        rtc_second_pulse,
  output wire        rtc_cal_tick,
  output wire        tamper_irq,
  output wire        tamper_event
);

  // ============================================================
  // Address helpers.
  function is_data;
    input [7:0] a;
    begin
      is_data = (a >= `BDT_OFS_DATA_FIRST) && (a <= `BDT_OFS_DATA_LAST) &&
                (a[1:0] == 2'b00);
    end
  endfunction

  function [`BDT_IDX_W-1:0] word_idx;
    input [7:0] a;
    reg   [7:0] d;
    begin
      d        = a - `BDT_OFS_DATA_FIRST;
      word_idx = d[`BDT_IDX_W+1:2];
    end
  endfunction

  // ============================================================
  // State.
  reg                  ack_r;
  reg [31:0]           prdata_r;
  reg                  power_if_clock_enable_r;
  reg                  bifen_r;
  reg                  unlock_r;
  reg                  bifrst_r;
  reg                  backup_domain_soft_reset_r;
  reg [`BDT_CAL_W-1:0] cal_r;
  reg                  cco_r;
  reg                  poe_r;
  reg                  pos_r;
  reg                  tpe_r;
  reg                  tamper_active_level_r;
  reg                  tpie_r;
  reg                  tef_r;
  reg                  tif_r;
  reg                  pend_r;
  reg                  act_d_r;
  reg                  tpe_d_r;
  reg                  false_r;
  reg [4:0]            div_cnt_r;
  reg                  div_clk_r;
  reg [WIN_W-1:0]      win_cnt_r;
  reg                  cal_tick_r;
  reg                  pin_out_r;
  reg                  pin_oe_n_r;

  wire                  pin_lvl;
  wire [`BDT_WORD_W-1:0] mem_rdata;
  wire                  bd_rst_n;
  wire                  access;
  wire                  wr;
  wire                  clk_ok;
  wire                  mapped;
  wire                  blocked;
  wire                  wr_ok;
  wire                  act;
  wire                  act_edge;
  wire                  tpe_rise;
  wire                  evt;
  wire                  wr_tcsr;
  wire                  drop;
  wire                  cte_wr;
  wire                  cti_wr;

  // ============================================================
  // Pin synchroniser and retained store.
  bdt_sync u_sync (
    .clk   (pclk),
    .rst_n (bat_rst_n),
    .din   (tamper_in),
    .dout  (pin_lvl)
  ); // R19

  assign bd_rst_n = bat_rst_n;

  bdt_mem u_mem (
    .clk   (pclk),
    .rst_n (bd_rst_n),
    .clr   (evt | backup_domain_soft_reset_r),
    .we    (wr_ok && is_data(paddr)),
    .waddr (word_idx(paddr)),
    .wdata (pwdata[`BDT_WORD_W-1:0]),
    .raddr (word_idx(paddr)),
    .rdata (mem_rdata)
  ); // R1 R4 R14

  // ============================================================
  // APB decode: one wait state gives the store time to answer.
  assign access  = psel & penable;
  assign wr      = access & ack_r & pwrite;
  assign clk_ok  = power_if_clock_enable_r & bifen_r; // R2
  assign mapped  = is_data(paddr) || (paddr == `BDT_OFS_CAL) ||
                   (paddr == `BDT_OFS_TCTL) || (paddr == `BDT_OFS_TCSR) ||
                   (paddr == `BDT_OFS_DCTL);
  // Unit registers need clocks; writes also need the unlock bit.
  assign blocked = (paddr != `BDT_OFS_DCTL) &&
                   (!clk_ok || (pwrite && !unlock_r)); // R2
  assign wr_ok   = wr & mapped & ~blocked;
  assign pready  = ack_r;
  assign pslverr = ack_r & (~mapped | blocked);
  assign prdata  = prdata_r;
  assign wr_tcsr = wr_ok && (paddr == `BDT_OFS_TCSR);
  assign cte_wr  = wr_tcsr & pwdata[`BDT_CTE_BIT];
  assign cti_wr  = wr_tcsr & pwdata[`BDT_CTI_BIT];

  // ============================================================
  // Handshake and read data capture in the first access cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_r    <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      ack_r <= access & ~ack_r;
      if (access && !ack_r) begin
        prdata_r <= 32'h00000000;
        if (!pwrite && mapped && !blocked) begin
          if (is_data(paddr)) begin
            prdata_r <= {16'h0000, mem_rdata};
          end else if (paddr == `BDT_OFS_CAL) begin
            prdata_r <= {22'h000000, pos_r, poe_r, cco_r, cal_r};
          end else if (paddr == `BDT_OFS_TCTL) begin
            prdata_r <= {30'h00000000, tamper_active_level_r, tpe_r};
          end else if (paddr == `BDT_OFS_TCSR) begin
            prdata_r <= {22'h000000, tif_r, tef_r, 5'h00, tpie_r, 2'h0};
          end else begin
            prdata_r <= {15'h0000, backup_domain_soft_reset_r, 12'h000, bifrst_r, unlock_r,
                         bifen_r, power_if_clock_enable_r};
          end
        end
      end
    end
  end

  // ============================================================
  // Domain control lives on the main supply side.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_if_clock_enable_r  <= 1'b0;
      bifen_r  <= 1'b0;
      unlock_r <= 1'b0;
      bifrst_r <= 1'b0;
      backup_domain_soft_reset_r  <= 1'b0;
    end else if (wr && paddr == `BDT_OFS_DCTL) begin
      power_if_clock_enable_r  <= pwdata[`BDT_POWER_IF_CLOCK_ENABLE_BIT];
      bifen_r  <= pwdata[`BDT_BIFEN_BIT];
      unlock_r <= pwdata[`BDT_UNLOCK_BIT];
      bifrst_r <= pwdata[`BDT_BIFRST_BIT];
      backup_domain_soft_reset_r  <= pwdata[`BDT_BACKUP_DOMAIN_SOFT_RESET_BIT];
    end
  end

  // ============================================================
  // Calibration value and clock-out bit drop with the main supply;
  // the interface reset clears them but not the pulse bits.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_r <= 7'h00;
      cco_r <= 1'b0;
    end else if (bifrst_r || backup_domain_soft_reset_r) begin
      cal_r <= 7'h00;
      cco_r <= 1'b0;
    end else if (wr_ok && paddr == `BDT_OFS_CAL) begin
      cal_r <= pwdata[`BDT_CAL_LSB +: `BDT_CAL_W]; // R13
      cco_r <= pwdata[`BDT_CCO_BIT];
    end
  end

  // ============================================================
  // Battery-held pulse bits and tamper control.
  always @(posedge pclk or negedge bat_rst_n) begin
    if (!bat_rst_n) begin
      poe_r  <= 1'b0;
      pos_r  <= 1'b0;
      tpe_r  <= 1'b0;
      tamper_active_level_r <= 1'b0;
      tpie_r <= 1'b0;
    end else if (backup_domain_soft_reset_r) begin
      poe_r  <= 1'b0; // R14
      pos_r  <= 1'b0; // R14
      tpe_r  <= 1'b0;
      tamper_active_level_r <= 1'b0;
      tpie_r <= 1'b0;
    end else begin
      if (wr_ok && paddr == `BDT_OFS_CAL) begin
        poe_r <= pwdata[`BDT_POE_BIT];
        pos_r <= pwdata[`BDT_POS_BIT];
      end
      if (wr_ok && paddr == `BDT_OFS_TCTL) begin
        tpe_r  <= pwdata[`BDT_TPE_BIT];
        tamper_active_level_r <= pwdata[`BDT_TAMPER_ACTIVE_LEVEL_BIT];
      end
      if (wr_tcsr) begin
        tpie_r <= pwdata[`BDT_TPIE_BIT];
      end
    end
  end

  // ============================================================
  // Edge detection on the polarity-corrected level. act_d starts low,
  // so a pin already active out of reset counts as a locked edge.
  assign act      = pin_lvl ^ tamper_active_level_r; // R15
  assign act_edge = act & ~act_d_r; // R3
  assign tpe_rise = tpe_r & ~tpe_d_r;
  assign evt      = (tpe_r & (act_edge | pend_r)) | // R3 R6
                    (tpe_rise & act) | // R7
                    false_r; // R18
  assign tamper_event = evt;

  // ============================================================
  // Event memory, flags and the false event on a joint clear.
  always @(posedge pclk or negedge bat_rst_n) begin
    if (!bat_rst_n) begin
      act_d_r <= 1'b0;
      tpe_d_r <= 1'b0;
      pend_r  <= 1'b0;
      tef_r   <= 1'b0;
      tif_r   <= 1'b0;
      false_r <= 1'b0;
    end else begin
      act_d_r <= act;
      tpe_d_r <= tpe_r;
      // Pulses when level and enable fall together in one write.
      false_r <= wr_ok && (paddr == `BDT_OFS_TCTL) && tpe_r && tamper_active_level_r &&
                 !pwdata[`BDT_TPE_BIT] && !pwdata[`BDT_TAMPER_ACTIVE_LEVEL_BIT]; // R18
      if (act_edge && !tpe_r) begin
        pend_r <= 1'b1; // R6
      end else if (evt || cte_wr || backup_domain_soft_reset_r) begin
        pend_r <= 1'b0;
      end
      // A new event beats a clear arriving in the same cycle.
      if (evt) begin
        tef_r <= 1'b1;
      end else if (cte_wr || backup_domain_soft_reset_r) begin
        tef_r <= 1'b0;
      end
      if (evt && tpie_r) begin
        tif_r <= 1'b1; // R5 R19
      end else if (cti_wr || backup_domain_soft_reset_r) begin
        tif_r <= 1'b0; // R19
      end
    end
  end

  assign tamper_irq = tif_r; // R5

  // ============================================================
  // RTC clock over 64 and skip-count calibration of the RTC ticks.
  // Dropped ticks sit at the start of each window, so the error is
  // lumped rather than spread; long-term rate is what matters.
  assign drop = (win_cnt_r < {{(WIN_W-`BDT_CAL_W){1'b0}}, cal_r}); // R17

  always @(posedge pclk or negedge bat_rst_n) begin
    if (!bat_rst_n) begin
      div_cnt_r  <= 5'h00;
      div_clk_r  <= 1'b0;
      win_cnt_r  <= {WIN_W{1'b0}};
      cal_tick_r <= 1'b0;
    end else begin
      cal_tick_r <= rtc_tick & ~drop; // R17
      if (rtc_tick) begin
        win_cnt_r <= win_cnt_r + 1'b1;
        div_cnt_r <= div_cnt_r + 5'h01;
        if (div_cnt_r == `BDT_DIV_HALF) begin
          div_clk_r <= ~div_clk_r; // R12
        end
      end
    end
  end

  assign rtc_cal_tick = cal_tick_r;

  // ============================================================
  // Pin mux: tamper use keeps the pin an input; clock out beats pulses.
  always @(posedge pclk or negedge bat_rst_n) begin
    if (!bat_rst_n) begin
      pin_out_r  <= 1'b0;
      pin_oe_n_r <= 1'b1;
    end else if (tpe_r) begin
      pin_out_r  <= 1'b0;
      pin_oe_n_r <= 1'b1; // R9
    end else if (cco_r) begin
      pin_out_r  <= div_clk_r; // R12
      pin_oe_n_r <= 1'b0;
    end else if (poe_r) begin
      pin_out_r  <= pos_r ? rtc_second_pulse : rtc_alarm_pulse; // R11 R16
      pin_oe_n_r <= 1'b0; // R11
    end else begin
      pin_out_r  <= 1'b0;
      pin_oe_n_r <= 1'b1;
    end
  end

  assign tamper_out  = pin_out_r;
  assign tamper_oe_n = pin_oe_n_r;

endmodule // bdt_top

`default_nettype wire

// ### tb/bdt_pin_model.sv
// Purpose: Far side of the tamper pin: a switch and an edge counter.
// Assumes: tamper_oe_n is low while the unit drives the pin.
// Notes  : The switch sets the level whenever the unit lets go.
`timescale 1ns/1ps
`default_nettype none

module bdt_pin_model (
  input  wire logic        pclk,
  input  wire logic        tamper_out,
  input  wire logic        tamper_oe_n,
  input  wire logic        sw_level,
  input  wire logic        clr,
  output wire logic        pin,
  output var  logic [15:0] edges
);
  logic prev_r;
  // ============================================================
  // Pin level
  // The switch never fights the unit, so no contention is modelled.
  assign pin = tamper_oe_n ? sw_level : tamper_out;
  // Count transitions that the unit itself puts on the pin.
  always @(posedge pclk) begin
    prev_r <= pin;
    if (clr)
      edges <= 16'h0000;
    else if (!tamper_oe_n && pin != prev_r)
      edges <= edges + 16'h0001;
  end
endmodule // bdt_pin_model
`default_nettype wire

// ### tb/bdt_top_checker.sv
// Purpose: Port-level timing checks of the backup domain unit.
// Assumes: One clock; helper state mirrors software writes.
// Notes  : Helper copies follow writes only, not the design state.
`timescale 1ns/1ps
`default_nettype none
`include "bdt_defs.vh"

module bdt_top_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        bat_rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        tamper_oe_n,
  input wire logic        rtc_tick,
  input wire logic        rtc_cal_tick,
  input wire logic        tamper_irq,
  input wire logic        tamper_event
);
  logic [16:0] dctl_r;
  logic        tpe_r;
  logic        tpie_r;
  wire acc = psel && penable && pready;
  wire wr = acc && pwrite;
  wire unl = dctl_r[0] && dctl_r[1] && dctl_r[2] && !dctl_r[16];
  wire inr = paddr >= `BDT_OFS_DATA_FIRST && paddr <= `BDT_OFS_TCSR;
  // ============================================================
  // Helper copies of the control bits
  // Domain control follows every write; it is always reachable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      dctl_r <= 17'h00000;
    else if (wr && paddr == `BDT_OFS_DCTL)
      dctl_r <= pwdata[16:0];
  end
  // Enables live on the battery side and die in a domain reset.
  always_ff @(posedge pclk or negedge bat_rst_n) begin
    if (!bat_rst_n) begin
      tpe_r <= 1'b0;
      tpie_r <= 1'b0;
    end else if (dctl_r[16]) begin
      tpe_r <= 1'b0;
      tpie_r <= 1'b0;
    end else begin
      if (wr && unl && paddr == `BDT_OFS_TCTL)
        tpe_r <= pwdata[0];
      if (wr && unl && paddr == `BDT_OFS_TCSR)
        tpie_r <= pwdata[2];
    end
  end
  // ============================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !bat_rst_n);
  a_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 0)
    else $error("refused read returned data");
  a_no_clock: assert property (acc && inr && dctl_r[1:0] != 2'b11 |-> pslverr)
    else $error("access without clocks accepted");
  a_locked_wr: assert property (wr && inr && !dctl_r[2] |-> pslverr)
    else $error("write without unlock accepted");
  a_irq_sticky: assert property (tamper_irq && !dctl_r[16]
    && !(wr && paddr == `BDT_OFS_TCSR && pwdata[1]) |=> tamper_irq)
    else $error("irq flag dropped without clear");
  a_irq_raise: assert property (tamper_event && tpie_r && !dctl_r[16]
    |=> tamper_irq)
    else $error("enabled event raised no irq");
  a_pin_input: assert property (tpe_r |=> tamper_oe_n)
    else $error("pin driven while detecting");
  a_cal_src: assert property (rtc_cal_tick |-> $past(rtc_tick))
    else $error("calibrated tick without rtc tick");
endmodule // bdt_top_checker

bind bdt_top bdt_top_checker chk_u (.pclk(pclk), .presetn(presetn),
  .bat_rst_n(bat_rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .tamper_oe_n(tamper_oe_n), .rtc_tick(rtc_tick),
  .rtc_cal_tick(rtc_cal_tick), .tamper_irq(tamper_irq),
  .tamper_event(tamper_event));
`default_nettype wire

// ### tb/bdt_top_test.sv
// Purpose: Self-checking bench of the backup domain unit.
// Assumes: APB master changes signals only after rising edges.
// Notes  : Retained words are mirrored in an integer array.
`timescale 1ns/1ps
`default_nettype none
`include "bdt_defs.vh"

module bdt_top_test;
  localparam [7:0] W0 = `BDT_OFS_DATA_FIRST, CAL = `BDT_OFS_CAL;
  localparam [7:0] TC = `BDT_OFS_TCTL, TS = `BDT_OFS_TCSR;
  localparam [7:0] DC = `BDT_OFS_DCTL;
  logic pclk = 0, presetn = 0, bat_rst_n = 0, psel = 0, penable = 0;
  logic pwrite = 0, rtc_tick = 0, al = 0, sec = 0, sw = 0, clr = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, r;
  logic e;
  wire [31:0] prdata;
  wire [15:0] edges;
  wire pready, pslverr, tout, toe_n, cal_tick, irq, ev, pin;
  int mismatches = 0, num_checks = 0, cal_n = 0, i, mw[10];

  bdt_top #(.WIN_W(8)) dut_u (.pclk(pclk), .presetn(presetn),
    .bat_rst_n(bat_rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tamper_in(pin),
    .tamper_out(tout), .tamper_oe_n(toe_n), .rtc_tick(rtc_tick),
    .rtc_alarm_pulse(al), .rtc_second_pulse(sec),
    .rtc_cal_tick(cal_tick), .tamper_irq(irq), .tamper_event(ev));
  bdt_pin_model pin_u (.pclk(pclk), .tamper_out(tout),
    .tamper_oe_n(toe_n), .sw_level(sw), .clr(clr), .pin(pin),
    .edges(edges));

  // ============================================================
  // Clock, tick counter and watchdog
  always #12.5 pclk = ~pclk;
  // Calibrated ticks are counted so drops show up as a total.
  always @(posedge pclk) if (cal_tick === 1'b1) cal_n++;
  // A hang anywhere ends the run as a failure.
  initial begin
    #(25 * 20000);
    mismatches++;
    end_sim;
  end

  // ============================================================
  // Tasks
  task check(input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, s, x);
    end
  endtask
  // pready is read at the rising edge, before that edge's updates land,
  // so the bench sees exactly what the slave samples; data taken there.
  task apb(input [7:0] a, input w, input [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) mismatches++;
    r = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task wr(input [7:0] a, input [31:0] d, input xe);
    apb(a, 1, d);
    check(32'(e), 32'(xe));
  endtask
  task rd(input [7:0] a, input [31:0] x, input xe);
    apb(a, 0, 0);
    check(r, x);
    check(32'(e), 32'(xe));
  endtask
  task fill;
    for (i = 0; i < 10; i++) begin
      mw[i] = $urandom & 16'hFFFF;
      wr(W0 + 8'(4 * i), mw[i], 0);
    end
  endtask
  task vfy;
    for (i = 0; i < 10; i++) rd(W0 + 8'(4 * i), mw[i], 0);
  endtask
  task wipe;
    for (i = 0; i < 10; i++) mw[i] = 0;
  endtask
  // Sees whether one event fires in a window longer than the filter.
  task evw(input logic x);
    logic s;
    s = 0;
    repeat (12) @(negedge pclk) if (ev === 1'b1) s = 1;
    check(32'(s), 32'(x));
  endtask
  task pulse(input logic p);
    @(posedge pclk) if (p) sec <= 1; else al <= 1;
    @(posedge pclk) begin sec <= 0; al <= 0; end
    repeat (3) @(posedge pclk);
  endtask
  task end_sim;
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ============================================================
  // Tests
  initial begin
    void'($urandom(77734));
    repeat (2) @(posedge pclk);
    presetn <= 1; bat_rst_n <= 1;
    rd(W0, 0, 1);
    wr(DC, 3, 0);
    wr(W0, 32'h1234, 1);
    rd(W0, 0, 0);
    wr(DC, 7, 0);
    fill;
    vfy;
    rd(8'h00, 0, 1);
    $display("Test access done");
    wr(TS, 5, 0);
    wr(TC, 1, 0);
    evw(0);
    sw <= 1;
    evw(1);
    wipe;
    vfy;
    rd(TS, 32'h304, 0);
    check(32'(irq), 1);
    sw <= 0;
    evw(0);
    wr(TS, 6, 0);
    rd(TS, 32'h104, 0);
    $display("Test rising done");
    wr(TC, 2, 0);
    wr(TS, 3, 0);
    fill;
    sw <= 1;
    evw(0);
    sw <= 0;
    evw(0);
    vfy;
    wr(TC, 3, 0);
    evw(1);
    wipe;
    vfy;
    rd(TS, 32'h100, 0);
    sw <= 1;
    evw(0);
    wr(TS, 1, 0);
    wr(TC, 0, 0);
    evw(1);
    wr(TS, 1, 0);
    wr(TC, 1, 0);
    evw(1);
    wr(TC, 0, 0);
    sw <= 0;
    $display("Test latched done");
    wr(CAL, 32'h85, 0);
    rd(CAL, 32'h85, 0);
    @(posedge pclk) clr <= 1;
    @(posedge pclk) clr <= 0;
    cal_n = 0;
    repeat (256) begin
      @(posedge pclk) rtc_tick <= 1;
      @(posedge pclk) rtc_tick <= 0;
    end
    repeat (4) @(posedge pclk);
    check(32'(edges), 8);
    check(cal_n, 251);
    $display("Test calibration done");
    for (int s = 0; s < 2; s++) begin
      wr(CAL, 32'h100 | (s << 9), 0);
      @(posedge pclk) clr <= 1;
      @(posedge pclk) clr <= 0;
      pulse(s == 0);
      pulse(s == 1);
      check(32'(edges), 2);
    end
    $display("Test pulse done");
    wr(CAL, 32'h300, 0);
    fill;
    wr(DC, 32'hF, 0);
    wr(DC, 7, 0);
    vfy;
    rd(CAL, 32'h300, 0);
    wr(DC, 32'h10007, 0);
    wr(DC, 7, 0);
    wipe;
    vfy;
    rd(CAL, 0, 0);
    $display("Test resets done");
    end_sim;
  end
endmodule // bdt_top_test
`default_nettype wire
